// ---- dv/ptf_charger_model.sv ----
// charger model sharing the thermistor and charger sense contacts of the pack
`timescale 1ns/1ps
module ptf_charger_model
(
  input wire logic attached,
  input wire logic ts_pull_oe_n,
  output logic charger_sense_input,
  output logic ts_ext_pullup
);
  // =====================================
  // shared line
  // the charger bias loses to the device pulldown; detached, the line falls low
  always_comb
  begin
    ts_ext_pullup = attached && ts_pull_oe_n;
    charger_sense_input = attached && ts_pull_oe_n;
  end
endmodule : ptf_charger_model

// ---- dv/tb_ptf_fault_logic.sv ----
// self-checking bench for the pack thermal and undervoltage fault logic
`timescale 1ns/1ps
module tb_ptf_fault_logic;
  import ptf_pkg::*;
  localparam logic [CNT_W-1:0] P_REL = 32'h0000_0014;
  localparam logic [CNT_W-1:0] P_PER = 32'h0000_0064;
  localparam logic [CNT_W-1:0] P_SD = 32'h0000_0032;
  localparam logic [CNT_W-1:0] P_FILT = 32'h0000_0004;
  localparam logic [CNT_W-1:0] P_TPER = 32'h0000_0040;
  localparam logic [CNT_W-1:0] P_TWIN = 32'h0000_0008;
  logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, attached = 1'b0;
  logic ts_below_hot = 1'b0, ts_open_or_cold = 1'b0, ts_shorted = 1'b0;
  logic cell_uv_any = 1'b0, cells_below_hyst_all = 1'b0, cells_above_hyst_all = 1'b1;
  logic load_removed = 1'b0, ov_fault = 1'b0, ov_signal_via_thermistor = 1'b0;
  logic temp_monitor_disable = 1'b0, uv_recovery_needs_load_removal = 1'b0;
  logic uv_shutdown_enable = 1'b0;
  logic [CNT_W-1:0] undervoltage_delay_time = 32'h0000_0008;
  logic charge_fet_drive, discharge_fet_drive, thermistor_bias_output, ts_pull_oe_n, ts_pull_out;
  logic regulator_enable, in_shutdown, charger_present, charger_sense_input, ts_ext_pullup;
  int error_cnt = 0, compares = 0, cycles = 0, c, d;

  ptf_fault_logic #(.OV_REL(P_REL), .OV_PER(P_PER), .UV_SD(P_SD), .FILT(P_FILT),
    .TS_PER(P_TPER), .TS_WIN(P_TWIN)) u_dut (.clk_sys, .rst_n, .clk_en, .ts_below_hot,
    .ts_open_or_cold, .ts_shorted, .ts_ext_pullup, .cell_uv_any, .cells_below_hyst_all,
    .cells_above_hyst_all, .load_removed, .charger_sense_input, .ov_fault,
    .ov_signal_via_thermistor, .temp_monitor_disable, .uv_recovery_needs_load_removal,
    .uv_shutdown_enable, .undervoltage_delay_time, .charge_fet_drive, .discharge_fet_drive,
    .thermistor_bias_output, .ts_pull_out, .ts_pull_oe_n, .regulator_enable,
    .in_shutdown, .charger_present);
  ptf_charger_model u_chg (.attached, .ts_pull_oe_n, .charger_sense_input, .ts_ext_pullup);

  // =====================================
  // clock and timeout
  initial
  begin
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // =====================================
  // helpers
  function automatic int exp_released();
    return int'(P_REL);
  endfunction : exp_released
  function automatic logic exp_dsg_on_cells_ok(input int m);
    return (m == 0);
  endfunction : exp_dsg_on_cells_ok
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step
  task automatic chk(input logic seen, input logic exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask : chk
  // counts cycles in which the bias (sel 0) or the released line (sel 1) is high
  task automatic count_hi(input int sel, input int n, output int cnt);
    cnt = 0;
    repeat (n)
    begin
      step(1);
      cnt += int'((sel == 0 ? thermistor_bias_output : ts_pull_oe_n) === 1'b1);
    end
  endtask : count_hi
  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // =====================================
  // main sequence
  initial
  begin
    void'($urandom(44));
    step(8);
    rst_n = 1'b1;
    step(15);
    chk(discharge_fet_drive, 1'b1);
    chk(regulator_enable, 1'b1);
    count_hi(0, int'(P_TPER), c);
    chk(c == int'(P_TWIN), 1'b1);
    // glitch shorter than the filter must not open the FETs
    ts_below_hot = 1'b1;
    step($urandom_range(3, 1));
    ts_below_hot = 1'b0;
    step(12);
    chk(charge_fet_drive, 1'b1);
    // with the clock enable low a hot reading must not be taken in
    clk_en = 1'b0;
    ts_below_hot = 1'b1;
    step(12);
    chk(charge_fet_drive, 1'b1);
    ts_below_hot = 1'b0;
    clk_en = 1'b1;
    step(12);
    chk(charge_fet_drive, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      {ts_below_hot, ts_open_or_cold} = 2'h2 >> k;
      step(12);
      chk(charge_fet_drive, 1'b0);
      chk(discharge_fet_drive, 1'b0);
      chk(in_shutdown, 1'b0);
      {ts_below_hot, ts_open_or_cold} = 2'h0;
      step(12);
      chk(charge_fet_drive, 1'b1);
    end
    attached = 1'b1;
    step(12);
    chk(charger_present, 1'b1);
    count_hi(0, int'(P_TPER), c);
    chk(c == 0, 1'b1);
    {ov_fault, ov_signal_via_thermistor, temp_monitor_disable} = 3'h7;
    step(10);
    count_hi(1, int'(P_PER), c);
    chk(c == exp_released(), 1'b1);
    // the charger is found again inside the release slot, then masked when pulled low
    chk(charger_present, 1'b1);
    step(15);
    chk(ts_pull_oe_n, 1'b0);
    chk(ts_pull_out, 1'b0);
    chk(charger_present, 1'b0);
    ov_fault = 1'b0;
    step(3);
    chk(ts_pull_oe_n, 1'b1);
    {attached, temp_monitor_disable} = 2'h0;
    for (int m = 0; m < 2; m++)
    begin
      d = $urandom_range(20, 5);
      undervoltage_delay_time = CNT_W'(d);
      uv_recovery_needs_load_removal = m[0];
      {cell_uv_any, cells_below_hyst_all, cells_above_hyst_all} = 3'h6;
      step(d + 4);
      chk(discharge_fet_drive, 1'b1);
      step(10);
      chk(discharge_fet_drive, 1'b0);
      chk(charge_fet_drive, 1'b1);
      {cell_uv_any, cells_below_hyst_all, cells_above_hyst_all} = 3'h1;
      step(12);
      chk(discharge_fet_drive, exp_dsg_on_cells_ok(m));
      load_removed = 1'b1;
      step(12);
      chk(discharge_fet_drive, 1'b1);
      load_removed = 1'b0;
    end
    {cell_uv_any, cells_below_hyst_all, cells_above_hyst_all} = 3'h6;
    step(d + int'(P_SD) + 40);
    chk(in_shutdown, 1'b0);
    uv_shutdown_enable = 1'b1;
    step(int'(P_SD) + 20);
    chk(in_shutdown, 1'b1);
    chk(regulator_enable, 1'b0);
    {cell_uv_any, cells_below_hyst_all, cells_above_hyst_all} = 3'h1;
    step(30);
    chk(in_shutdown, 1'b1);
    attached = 1'b1;
    step(12);
    chk(in_shutdown, 1'b0);
    chk(regulator_enable, 1'b1);
    {attached, uv_shutdown_enable, ts_shorted} = 3'h1;
    step(12);
    chk(in_shutdown, 1'b1);
    chk(charge_fet_drive, 1'b0);
    ts_shorted = 1'b0;
    step(30);
    chk(in_shutdown, 1'b1);
    attached = 1'b1;
    step(12);
    chk(in_shutdown, 1'b0);
    chk(charge_fet_drive, 1'b1);
    report_and_stop();
  end
endmodule : tb_ptf_fault_logic

// ---- hw/ptf_fault_logic.sv ----
// fault decision logic: thermistor, undervoltage, overvoltage signalling, shutdown
// Functional notes
// - bias thermistor only when nobody else does
// - hot thermistor turns off both FETs
// - shorted thermistor opens FETs and shuts down
// - cold or open thermistor opens FETs, stays awake
// - overvoltage with option set pulls thermistor low
// - no charger detection while thermistor held low
// - pulldown ignores temperature monitor disable
// - release pulldown 200 ms every 4 s
// - undervoltage past delay turns off discharge FET
// - mode 0 recovers above threshold plus hysteresis
// - mode 1 also needs load removal
// - shutdown enable: 8 s undervoltage enters shutdown
// - shutdown disabled: undervoltage never shuts down
// - only charger insertion leaves shutdown
// - regulator off in shutdown
// - charger sense detection wakes from shutdown
// - open thermistor clears after filter time
// - external pullup seen keeps own bias off
`timescale 1ns/1ps
module ptf_fault_logic
  import ptf_pkg::*;
#(
  parameter logic [ptf_pkg::CNT_W-1:0] OV_REL = ptf_pkg::OV_REL_CYC,
  parameter logic [ptf_pkg::CNT_W-1:0] OV_PER = ptf_pkg::OV_PER_CYC,
  parameter logic [ptf_pkg::CNT_W-1:0] UV_SD = ptf_pkg::UV_SD_CYC,
  parameter logic [ptf_pkg::CNT_W-1:0] FILT = ptf_pkg::FILT_CYC,
  parameter logic [ptf_pkg::CNT_W-1:0] TS_PER = ptf_pkg::TS_PER_CYC,
  parameter logic [ptf_pkg::CNT_W-1:0] TS_WIN = ptf_pkg::TS_WIN_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic ts_below_hot,
  input wire logic ts_open_or_cold,
  input wire logic ts_shorted,
  input wire logic ts_ext_pullup,
  input wire logic cell_uv_any,
  input wire logic cells_below_hyst_all,
  input wire logic cells_above_hyst_all,
  input wire logic load_removed,
  input wire logic charger_sense_input,
  input wire logic ov_fault,
  input wire logic ov_signal_via_thermistor,
  input wire logic temp_monitor_disable,
  input wire logic uv_recovery_needs_load_removal,
  input wire logic uv_shutdown_enable,
  input wire logic [ptf_pkg::CNT_W-1:0] undervoltage_delay_time,
  output logic charge_fet_drive,
  output logic discharge_fet_drive,
  output logic thermistor_bias_output,
  output logic ts_pull_out,
  output logic ts_pull_oe_n,
  output logic regulator_enable,
  output logic in_shutdown,
  output logic charger_present
);
  import ptf_pkg::*;

  // =====================================
  // input synchronisers and filters
  logic [N_IN-1:0] raw;
  logic [N_IN-1:0] sync1_reg;
  logic [N_IN-1:0] sync2_reg;
  logic [N_IN-1:0] flt_reg;

  assign raw[IX_HOT] = ts_below_hot;
  assign raw[IX_OPEN] = ts_open_or_cold;
  assign raw[IX_SHORT] = ts_shorted;
  assign raw[IX_EXTPU] = ts_ext_pullup;
  assign raw[IX_UV] = cell_uv_any;
  assign raw[IX_BELOW] = cells_below_hyst_all;
  assign raw[IX_ABOVE] = cells_above_hyst_all;
  assign raw[IX_LOAD] = load_removed;
  assign raw[IX_CHG] = charger_sense_input;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_reg <= IN_RST;
      sync2_reg <= IN_RST;
    end
    else if (clk_en)
    begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // a level is accepted only after it differs for the whole filter time
  for (genvar gi = 0; gi < N_IN; gi++)
  begin : g_flt
    logic [CNT_W-1:0] fcnt_reg;
    always_ff @(posedge clk_sys)
    begin
      if (!rst_n)
      begin
        fcnt_reg <= CNT_ZERO;
        flt_reg[gi] <= 1'b0;
      end
      else if (clk_en)
      begin
        if (sync2_reg[gi] == flt_reg[gi])
          fcnt_reg <= CNT_ZERO;
        else if (fcnt_reg >= FILT - CNT_ONE)
        begin
          fcnt_reg <= CNT_ZERO;
          flt_reg[gi] <= sync2_reg[gi];
        end
        else
          fcnt_reg <= fcnt_reg + CNT_ONE;
      end
    end
  end

  // =====================================
  // overvoltage pulldown of the thermistor line
  ptf_state_e state_reg;
  ptf_state_e state_next;
  logic [CNT_W-1:0] ov_cnt_reg;
  wire ov_sig = ov_fault && ov_signal_via_thermistor && (state_next != ST_SD);
  wire ov_release = ov_cnt_reg < OV_REL;
  wire pd_next = ov_sig && !ov_release;
  wire chg_seen = flt_reg[IX_CHG] && ts_pull_oe_n;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ov_cnt_reg <= CNT_ZERO;
    else if (clk_en)
    begin
      if (!ov_sig || ov_cnt_reg >= OV_PER - CNT_ONE)
        ov_cnt_reg <= CNT_ZERO;
      else
        ov_cnt_reg <= ov_cnt_reg + CNT_ONE;
    end
  end

  // =====================================
  // thermistor check window and bias
  logic [CNT_W-1:0] ts_cnt_reg;
  wire ts_win = ts_cnt_reg < TS_WIN;
  wire mon_on = !temp_monitor_disable;
  wire hot_f = mon_on && flt_reg[IX_HOT];
  wire open_f = mon_on && flt_reg[IX_OPEN];
  wire short_f = mon_on && flt_reg[IX_SHORT];
  wire bias_next = ts_win && mon_on && !flt_reg[IX_EXTPU] && !pd_next
    && (state_next != ST_SD);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      ts_cnt_reg <= CNT_ZERO;
    else if (clk_en)
    begin
      if (ts_cnt_reg >= TS_PER - CNT_ONE)
        ts_cnt_reg <= CNT_ZERO;
      else
        ts_cnt_reg <= ts_cnt_reg + CNT_ONE;
    end
  end

  // =====================================
  // undervoltage timing
  logic [CNT_W-1:0] uv_cnt_reg;
  logic [CNT_W-1:0] sd_cnt_reg;
  wire uv_trip = flt_reg[IX_UV] && (uv_cnt_reg > undervoltage_delay_time);
  wire uv_load_ok = !uv_recovery_needs_load_removal || flt_reg[IX_LOAD];
  wire uv_recover = flt_reg[IX_ABOVE] && uv_load_ok;
  wire uv_sd = uv_shutdown_enable && (sd_cnt_reg > UV_SD);
  wire sd_go = short_f || ((state_reg == ST_UV) && uv_sd);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      uv_cnt_reg <= CNT_ZERO;
      sd_cnt_reg <= CNT_ZERO;
    end
    else if (clk_en)
    begin
      if (!flt_reg[IX_UV] || state_reg != ST_ACTIVE)
        uv_cnt_reg <= CNT_ZERO;
      else if (!uv_trip)
        uv_cnt_reg <= uv_cnt_reg + CNT_ONE;
      if (state_reg != ST_UV || !flt_reg[IX_BELOW])
        sd_cnt_reg <= CNT_ZERO;
      else if (!uv_sd)
        sd_cnt_reg <= sd_cnt_reg + CNT_ONE;
    end
  end

  // =====================================
  // operating state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_ACTIVE:
        if (sd_go)
          state_next = ST_SD;
        else if (uv_trip)
          state_next = ST_UV;
      ST_UV:
        if (sd_go)
          state_next = ST_SD;
        else if (uv_recover)
          state_next = ST_ACTIVE;
      ST_SD:
        if (chg_seen)
          state_next = ST_ACTIVE;
      default:
        state_next = ST_SD;
    endcase
  end

  // hot and open thermistor faults open both FETs without leaving the active state
  wire therm_bad = hot_f || open_f || short_f;
  wire sd_n = state_next != ST_SD;
  wire chg_next = sd_n && !therm_bad;
  wire dsg_next = sd_n && !therm_bad && (state_next != ST_UV);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_ACTIVE;
      charge_fet_drive <= 1'b0;
      discharge_fet_drive <= 1'b0;
      thermistor_bias_output <= 1'b0;
      ts_pull_oe_n <= 1'b1;
      regulator_enable <= 1'b1;
      in_shutdown <= 1'b0;
      charger_present <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      charge_fet_drive <= chg_next;
      discharge_fet_drive <= dsg_next;
      thermistor_bias_output <= bias_next;
      ts_pull_oe_n <= !pd_next;
      regulator_enable <= sd_n;
      in_shutdown <= !sd_n;
      charger_present <= chg_seen;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    ts_pull_out <= 1'b0;
  end

  // =====================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // a charger wake with the short still present may leave shutdown for one cycle
  sequence s_short_seen;
    clk_en && short_f && !(state_reg == ST_SD && chg_seen);
  endsequence

  sequence s_sd_entered;
    state_reg == ST_SD && !regulator_enable;
  endsequence

  a_hot_fets_off: assert property (clk_en && hot_f
    |=> !charge_fet_drive && !discharge_fet_drive)
    else $error("hot thermistor left a FET on");
  a_short_shutdown: assert property (s_short_seen |=> s_sd_entered)
    else $error("short did not shut down");
  a_open_stays_awake: assert property (clk_en && open_f && !short_f
    && state_reg == ST_ACTIVE |=> !charge_fet_drive && regulator_enable)
    else $error("open thermistor handling wrong");
  a_ov_pulldown: assert property (clk_en && ov_fault && ov_signal_via_thermistor
    && state_next != ST_SD && ov_cnt_reg >= OV_REL |=> !ts_pull_oe_n && !thermistor_bias_output)
    else $error("pulldown not applied");
  a_pd_release: assert property (clk_en && ov_release |=> ts_pull_oe_n)
    else $error("line held low in release slot");
  a_pd_no_charger: assert property (clk_en && !ts_pull_oe_n |=> !charger_present)
    else $error("charger detection while line low");
  a_bias_not_shared: assert property (thermistor_bias_output
    |-> ts_pull_oe_n && !$past(flt_reg[IX_EXTPU]))
    else $error("bias while line is externally driven");
  a_uv_dsg_off: assert property (clk_en && state_reg == ST_UV && !uv_recover
    |=> !discharge_fet_drive)
    else $error("discharge FET on during undervoltage");
  a_sd_only_charger: assert property (clk_en && state_reg == ST_SD && !chg_seen
    |=> state_reg == ST_SD)
    else $error("left shutdown without charger");
  a_sd_no_uv: assert property (clk_en && !uv_shutdown_enable && !short_f
    && state_reg == ST_UV |=> state_reg != ST_SD)
    else $error("undervoltage shutdown while disabled");
  a_sd_reg_off: assert property (in_shutdown
    |-> !regulator_enable && !thermistor_bias_output && ts_pull_oe_n
    && !charge_fet_drive && !discharge_fet_drive)
    else $error("regulator or drive on in shutdown");
  a_uv_needs_load: assert property (clk_en && state_reg == ST_UV
    && uv_recovery_needs_load_removal && !flt_reg[IX_LOAD] |=> state_reg != ST_ACTIVE)
    else $error("undervoltage recovered without load removal");
  a_uv_mode0_recover: assert property (clk_en && state_reg == ST_UV && flt_reg[IX_ABOVE]
    && !uv_recovery_needs_load_removal && !short_f && !uv_sd |=> state_reg == ST_ACTIVE)
    else $error("undervoltage recovery late");
endmodule : ptf_fault_logic

// ---- hw/ptf_pkg.sv ----
// constants and types for the pack thermal and undervoltage fault logic
package ptf_pkg;
  // =====================================
  // clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned MS_DIV = 1000;
  localparam longint unsigned US_DIV = 1_000_000;
  localparam int unsigned OV_REL_MS = 200;
  localparam int unsigned OV_PER_MS = 4000;
  localparam int unsigned UV_SD_MS = 8000;
  localparam int unsigned FILT_US = 100;
  localparam int unsigned TS_PER_MS = 1000;
  localparam int unsigned TS_WIN_US = 1000;
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] OV_REL_CYC = CNT_W'(OV_REL_MS * longint'(CLK_HZ) / MS_DIV);
  localparam logic [CNT_W-1:0] OV_PER_CYC = CNT_W'(OV_PER_MS * longint'(CLK_HZ) / MS_DIV);
  localparam logic [CNT_W-1:0] UV_SD_CYC = CNT_W'(UV_SD_MS * longint'(CLK_HZ) / MS_DIV);
  localparam logic [CNT_W-1:0] FILT_CYC = CNT_W'(FILT_US * longint'(CLK_HZ) / US_DIV);
  localparam logic [CNT_W-1:0] TS_PER_CYC = CNT_W'(TS_PER_MS * longint'(CLK_HZ) / MS_DIV);
  localparam logic [CNT_W-1:0] TS_WIN_CYC = CNT_W'(TS_WIN_US * longint'(CLK_HZ) / US_DIV);
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  // =====================================
  // comparator input positions
  localparam int unsigned N_IN = 9;
  localparam int unsigned IX_HOT = 0;
  localparam int unsigned IX_OPEN = 1;
  localparam int unsigned IX_SHORT = 2;
  localparam int unsigned IX_EXTPU = 3;
  localparam int unsigned IX_UV = 4;
  localparam int unsigned IX_BELOW = 5;
  localparam int unsigned IX_ABOVE = 6;
  localparam int unsigned IX_LOAD = 7;
  localparam int unsigned IX_CHG = 8;
  localparam logic [N_IN-1:0] IN_RST = 9'h000;

  // =====================================
  // operating states
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h1,
    ST_UV = 3'h2,
    ST_SD = 3'h4
  } ptf_state_e;
endpackage : ptf_pkg
